// ---- bmpm_ctrl.sv ----
// power-mode controller with apb registers
`timescale 1ns/1ps
`include "bmpm_params.svh"

module bmpm_ctrl
#(
    parameter int SEC_CNT  = `BMPM_SEC_CNT,
    parameter int EXIT_CNT = `BMPM_MS_CNT(`BMPM_EXIT_MS),
    parameter int CUR_CNT  = `BMPM_US_CNT(`BMPM_CUR_PERIOD_US),
    parameter int VOLT_CNT = `BMPM_US_CNT(`BMPM_VOLT_PERIOD_US),
    parameter int SLP_CNT  = `BMPM_US_CNT(`BMPM_SLPCUR_US)
)
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // measurement comparisons, same clock
    input  wire logic        relaxed,
    input  wire logic        sleep_current_over,
    input  wire logic        interval_current_over,
    input  wire logic        pack_delta_wake,
    input  wire logic        protection_fault,
    input  wire logic        charger_attached,
    input  wire logic        stack_low,
    input  wire logic        cell_min_low,
    input  wire logic        int_temp_over,
    input  wire logic        hw_die_overtemp,
    input  wire logic        battery_supply_low,
    input  wire logic        mem_error,
    // asynchronous pins
    input  wire logic        reset_shut_pin,
    input  wire logic        load_detect_pin,
    input  wire logic        second_thermistor_wake_pin,
    // mode and drive outputs
    output logic [2:0]       power_mode,
    output logic             charge_fet,
    output logic             discharge_fet,
    output logic             protections_en,
    output logic             comparators_en,
    output logic             current_sample,
    output logic             voltage_sample,
    output logic             fast_conversion,
    output logic             data_valid,
    output logic             ldo_output_one,
    output logic             ldo_output_two,
    output logic             low_freq_oscillator,
    output logic             otp_reload,
    output logic             watchdog_reset
);

    bmpm_pkg::bmpm_regs_t r_ff;
    bmpm_pkg::bmpm_regs_t nxt_r;

    logic wr;
    logic rd;
    logic [3:0] cmd;
    logic rst_pin;
    logic ld_pin;
    logic ts2_pin;
    logic short_press;
    logic ld_rise;
    logic ts2_fall;
    logic shut_req;
    logic [31:0] cur_per;
    logic [31:0] volt_per;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign cmd = (wr && paddr == `BMPM_A_CMD) ? pwdata[3:0] : 4'h0;
    // level moves once second and third stages agree
    assign rst_pin = (r_ff.s2[0] == r_ff.s3[0]) ? r_ff.s3[0] : r_ff.rst_hi_prev;
    assign ld_pin  = (r_ff.s2[1] == r_ff.s3[1]) ? r_ff.s3[1] : r_ff.ld_prev;
    assign ts2_pin = (r_ff.s2[2] == r_ff.s3[2]) ? r_ff.s3[2] : r_ff.ts2_prev;
    // pin released after a press under one second
    assign short_press = r_ff.rst_hi_prev && !rst_pin && r_ff.rst_hi_cnt < 32'(SEC_CNT);
    assign ld_rise  = ld_pin && !r_ff.ld_prev;
    assign ts2_fall = !ts2_pin && r_ff.ts2_prev;
    assign cur_per  = r_ff.ctrl[`BMPM_B_FASTCONV] ? 32'(CUR_CNT / 2) : 32'(CUR_CNT);
    assign volt_per = (r_ff.ctrl[`BMPM_B_SLOW_VOLT] ? 32'(2 * VOLT_CNT) : 32'(VOLT_CNT))
                      >> r_ff.ctrl[`BMPM_B_FASTCONV];

    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.s1 = {second_thermistor_wake_pin, load_detect_pin, reset_shut_pin};
        nxt_r.s2 = r_ff.s1;
        nxt_r.s3 = r_ff.s2;
        nxt_r.rst_hi_prev = rst_pin;
        nxt_r.ld_prev = ld_pin;
        nxt_r.ts2_prev = ts2_pin;
        nxt_r.rst_hi_cnt = rst_pin ? r_ff.rst_hi_cnt + 32'h1 : 32'h0;
        nxt_r.cur_smp = 1'b0;
        nxt_r.volt_smp = 1'b0;
        nxt_r.slp_smp = 1'b0;
        nxt_r.wdog_rst = 1'b0;
        nxt_r.sec_pulse = 1'b0;
        // 1-s boundary
        if (r_ff.sec_cnt >= 32'(SEC_CNT - 1))
        begin
            nxt_r.sec_cnt = 32'h0;
            nxt_r.sec_pulse = 1'b1;
        end
        else
        begin
            nxt_r.sec_cnt = r_ff.sec_cnt + 32'h1;
        end
        // apb writes
        if (wr && r_ff.state != bmpm_pkg::ST_SHUTDOWN)
        begin
            if (paddr == `BMPM_A_CTRL)
            begin
                nxt_r.ctrl = pwdata;
            end
            else if (paddr == `BMPM_A_SLEEP_HYS)
            begin
                nxt_r.sleep_hys = pwdata[7:0];
                nxt_r.ot_dly = pwdata[15:8];
            end
            else if (paddr == `BMPM_A_SHUT_DLY)
            begin
                nxt_r.shut_dly = pwdata[7:0];
            end
            else if (paddr == `BMPM_A_MISC)
            begin
                nxt_r.reshut_min = pwdata[7:0];
                nxt_r.mem_win = pwdata[15:8];
            end
        end
        // sleep permit taken from config at power-up
        if (r_ff.tick == 32'h0)
        begin
            nxt_r.sleep_allow = r_ff.ctrl[`BMPM_B_SLEEP_CFG];
            nxt_r.tick = 32'h1;
        end
        if (cmd == `BMPM_CMD_SLP_ALLOW)
        begin
            nxt_r.sleep_allow = 1'b1;
        end
        else if (cmd == `BMPM_CMD_SLP_FORBID)
        begin
            nxt_r.sleep_allow = 1'b0;
        end
        if (r_ff.sec_pulse && r_ff.hys_left != 8'h0)
        begin
            nxt_r.hys_left = r_ff.hys_left - 8'h1;
        end
        if (r_ff.sec_pulse)
        begin
            nxt_r.ot_secs = int_temp_over ? r_ff.ot_secs + 8'h1 : 8'h0;
        end
        shut_req = (cmd == `BMPM_CMD_SHUTDOWN)
            || (r_ff.rst_hi_cnt >= 32'(SEC_CNT))
            || (r_ff.ctrl[`BMPM_B_AUTO_SHUT] && (stack_low || cell_min_low))
            || (r_ff.ctrl[`BMPM_B_OT_SHUT] && int_temp_over && r_ff.ot_secs >= r_ff.ot_dly)
            || (r_ff.ctrl[`BMPM_B_HWOT_SHUT] && hw_die_overtemp)
            || (r_ff.ctrl[`BMPM_B_RESHUT] && r_ff.woke
                && r_ff.wake_secs >= 16'(r_ff.reshut_min) * 16'(`BMPM_MIN_SECS));
        if (r_ff.sec_pulse && r_ff.woke)
        begin
            nxt_r.wake_secs = r_ff.wake_secs + 16'h1;
        end
        if (r_ff.sec_pulse && r_ff.mem_armed)
        begin
            nxt_r.mem_secs = r_ff.mem_secs + 8'h1;
            if (r_ff.mem_secs >= r_ff.mem_win)
            begin
                nxt_r.mem_armed = 1'b0;
            end
        end
        if (mem_error && (r_ff.state == bmpm_pkg::ST_NORMAL || r_ff.state == bmpm_pkg::ST_SLEEP))
        begin
            if (r_ff.mem_armed)
            begin
                shut_req = 1'b1;
            end
            else
            begin
                nxt_r.wdog_rst = 1'b1;
                nxt_r.mem_armed = 1'b1;
                nxt_r.mem_secs = 8'h0;
            end
        end
        case (r_ff.state)
            bmpm_pkg::ST_NORMAL:
            begin
                if (r_ff.wait_boundary)
                begin
                    if (r_ff.sec_pulse)
                    begin
                        nxt_r.wait_boundary = 1'b0;
                    end
                end
                else
                begin
                    nxt_r.cur_cnt = r_ff.cur_cnt + 32'h1;
                    nxt_r.volt_cnt = r_ff.volt_cnt + 32'h1;
                    if (r_ff.cur_cnt >= cur_per - 32'h1)
                    begin
                        nxt_r.cur_cnt = 32'h0;
                        nxt_r.cur_smp = 1'b1;
                    end
                    if (r_ff.volt_cnt >= volt_per - 32'h1)
                    begin
                        nxt_r.volt_cnt = 32'h0;
                        nxt_r.volt_smp = 1'b1;
                    end
                end
                if (shut_req)
                begin
                    nxt_r.state = bmpm_pkg::ST_SHUT_SEQ;
                    nxt_r.gen_cnt = 32'h0;
                end
                else if (cmd == `BMPM_CMD_DEEP_ENTER)
                begin
                    nxt_r.state = bmpm_pkg::ST_DEEP;
                    nxt_r.fets_on = 1'b0;
                    nxt_r.cur_smp = 1'b0;
                    nxt_r.volt_smp = 1'b0;
                end
                else if (relaxed && r_ff.sleep_allow && r_ff.hys_left == 8'h0)
                begin
                    nxt_r.state = bmpm_pkg::ST_SLEEP;
                    nxt_r.slp_cnt = 32'h0;
                    nxt_r.gen_cnt = 32'h0;
                end
            end
            bmpm_pkg::ST_SLEEP:
            begin
                nxt_r.slp_cnt = r_ff.slp_cnt + 32'h1;
                if (r_ff.slp_cnt >= 32'(SLP_CNT - 1))
                begin
                    nxt_r.slp_cnt = 32'h0;
                    nxt_r.slp_smp = 1'b1;
                end
                nxt_r.gen_cnt = r_ff.gen_cnt + 32'h1;
                if (r_ff.gen_cnt >= volt_per - 32'h1)
                begin
                    nxt_r.gen_cnt = 32'h0;
                    nxt_r.volt_smp = 1'b1;
                    nxt_r.cur_smp = 1'b1;
                end
                if (shut_req)
                begin
                    nxt_r.state = bmpm_pkg::ST_SHUT_SEQ;
                    nxt_r.gen_cnt = 32'h0;
                end
                else if (protection_fault || charger_attached || short_press
                    || cmd == `BMPM_CMD_SLP_EXIT || !r_ff.sleep_allow
                    || (r_ff.slp_smp && sleep_current_over)
                    || (r_ff.volt_smp && (interval_current_over || pack_delta_wake)))
                begin
                    nxt_r.state = bmpm_pkg::ST_NORMAL;
                    nxt_r.hys_left = r_ff.sleep_hys;
                    nxt_r.fets_on = 1'b1;
                    nxt_r.wait_boundary = r_ff.slp_smp && sleep_current_over;
                    nxt_r.cur_cnt = 32'h0;
                    nxt_r.volt_cnt = 32'h0;
                end
            end
            bmpm_pkg::ST_DEEP:
            begin
                if (battery_supply_low)
                begin
                    nxt_r.state = bmpm_pkg::ST_SHUTDOWN;
                end
                else if (cmd == `BMPM_CMD_DEEP_EXIT || short_press || ld_rise)
                begin
                    nxt_r.state = bmpm_pkg::ST_DEEP_EXIT;
                    nxt_r.gen_cnt = 32'h0;
                end
            end
            bmpm_pkg::ST_DEEP_EXIT:
            begin
                // settle plus full loop, then check
                nxt_r.gen_cnt = r_ff.gen_cnt + 32'h1;
                if (r_ff.gen_cnt == 32'(EXIT_CNT) + volt_per - 32'h1)
                begin
                    nxt_r.volt_smp = 1'b1;
                    nxt_r.cur_smp = 1'b1;
                end
                if (r_ff.gen_cnt >= 32'(EXIT_CNT) + volt_per)
                begin
                    nxt_r.state = bmpm_pkg::ST_NORMAL;
                    nxt_r.fets_on = !protection_fault;
                    nxt_r.cur_cnt = 32'h0;
                    nxt_r.volt_cnt = 32'h0;
                end
            end
            bmpm_pkg::ST_SHUT_SEQ:
            begin
                // delay, fets off, delay, wait load low
                if (r_ff.sec_pulse)
                begin
                    nxt_r.gen_cnt = r_ff.gen_cnt + 32'h1;
                end
                if (r_ff.gen_cnt >= 32'(r_ff.shut_dly))
                begin
                    nxt_r.fets_on = 1'b0;
                end
                if (r_ff.gen_cnt >= 32'(r_ff.shut_dly) * 32'h2 && !ld_pin)
                begin
                    nxt_r.state = bmpm_pkg::ST_SHUTDOWN;
                end
            end
            bmpm_pkg::ST_SHUTDOWN:
            begin
                nxt_r.ctrl = `BMPM_CTRL_RST;
                nxt_r.sleep_hys = `BMPM_HYS_RST;
                nxt_r.shut_dly = `BMPM_DLY_RST;
                nxt_r.ot_dly = `BMPM_OT_DLY_RST;
                nxt_r.reshut_min = `BMPM_RESHUT_RST;
                nxt_r.mem_win = `BMPM_MEMWIN_RST;
                nxt_r.sleep_allow = 1'b1;
                nxt_r.hys_left = 8'h0;
                nxt_r.woke = 1'b0;
                nxt_r.wake_secs = 16'h0;
                nxt_r.fets_on = 1'b0;
                if (ts2_fall || ld_rise)
                begin
                    nxt_r.state = bmpm_pkg::ST_NORMAL;
                    nxt_r.fets_on = 1'b1;
                    nxt_r.woke = 1'b1;
                    nxt_r.mem_armed = 1'b0;
                end
            end
            default:
            begin
                nxt_r.state = bmpm_pkg::ST_NORMAL;
            end
        endcase
        // apb read data captured in setup phase
        if (rd)
        begin
            if (paddr == `BMPM_A_CTRL)
            begin
                nxt_r.prdata = r_ff.ctrl;
            end
            else if (paddr == `BMPM_A_STATUS)
            begin
                nxt_r.prdata = {24'h0, r_ff.fets_on, r_ff.mem_armed, r_ff.woke,
                    r_ff.state, r_ff.state == bmpm_pkg::ST_SLEEP, r_ff.sleep_allow};
            end
            else if (paddr == `BMPM_A_SLEEP_HYS)
            begin
                nxt_r.prdata = {16'h0, r_ff.ot_dly, r_ff.sleep_hys};
            end
            else if (paddr == `BMPM_A_SHUT_DLY)
            begin
                nxt_r.prdata = {24'h0, r_ff.shut_dly};
            end
            else if (paddr == `BMPM_A_MISC)
            begin
                nxt_r.prdata = {16'h0, r_ff.mem_win, r_ff.reshut_min};
            end
            else
            begin
                nxt_r.prdata = 32'h0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r_ff <= '0;
            r_ff.ctrl <= `BMPM_CTRL_RST;
            r_ff.sleep_hys <= `BMPM_HYS_RST;
            r_ff.shut_dly <= `BMPM_DLY_RST;
            r_ff.ot_dly <= `BMPM_OT_DLY_RST;
            r_ff.reshut_min <= `BMPM_RESHUT_RST;
            r_ff.mem_win <= `BMPM_MEMWIN_RST;
            r_ff.sleep_allow <= 1'b1;
            r_ff.fets_on <= 1'b1;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    logic active;
    logic deep;
    assign active = r_ff.state == bmpm_pkg::ST_NORMAL || r_ff.state == bmpm_pkg::ST_SLEEP;
    assign deep = r_ff.state == bmpm_pkg::ST_DEEP || r_ff.state == bmpm_pkg::ST_DEEP_EXIT;

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = r_ff.prdata;
    assign power_mode = r_ff.state;
    assign charge_fet = r_ff.fets_on && active;
    assign discharge_fet = r_ff.fets_on && active;
    assign protections_en = active || r_ff.state == bmpm_pkg::ST_DEEP_EXIT;
    assign comparators_en = active;
    assign current_sample = r_ff.cur_smp || r_ff.slp_smp;
    assign voltage_sample = r_ff.volt_smp;
    assign fast_conversion = r_ff.ctrl[`BMPM_B_FASTCONV];
    assign data_valid = active && !r_ff.wait_boundary;
    assign ldo_output_one = (r_ff.state != bmpm_pkg::ST_SHUTDOWN)
        && (!deep || r_ff.ctrl[`BMPM_B_LDO1_KEEP]);
    assign ldo_output_two = (r_ff.state != bmpm_pkg::ST_SHUTDOWN)
        && (!deep || r_ff.ctrl[`BMPM_B_LDO2_KEEP]);
    assign low_freq_oscillator = (r_ff.state != bmpm_pkg::ST_SHUTDOWN)
        && (r_ff.state != bmpm_pkg::ST_DEEP || r_ff.ctrl[`BMPM_B_LFO_KEEP]);
    assign otp_reload = r_ff.woke && r_ff.wake_secs == 16'h0;
    assign watchdog_reset = r_ff.wdog_rst;

endmodule

// ---- bmpm_params.svh ----
// constants for the battery monitor power-mode controller
`ifndef BMPM_PARAMS_SVH
`define BMPM_PARAMS_SVH

`define BMPM_CLK_HZ          25000000
`define BMPM_NS_PER_CLK      40
`define BMPM_CUR_PERIOD_US   3000
`define BMPM_VOLT_PERIOD_US  63000
`define BMPM_SLPCUR_US       12000
`define BMPM_EXIT_MS         250
`define BMPM_PIN_SHORT_MS    1000
`define BMPM_CNT_W           32
`define BMPM_SEC_CNT         (`BMPM_CLK_HZ)
`define BMPM_US_CNT(us)      (((us) * 1000) / `BMPM_NS_PER_CLK)
`define BMPM_MS_CNT(ms)      (((ms) * 1000000) / `BMPM_NS_PER_CLK)
`define BMPM_MIN_SECS        60

`define BMPM_A_CTRL          32'h0000_0000
`define BMPM_A_STATUS        32'h0000_0004
`define BMPM_A_CMD           32'h0000_0008
`define BMPM_A_SLEEP_HYS     32'h0000_000C
`define BMPM_A_SHUT_DLY      32'h0000_0010
`define BMPM_A_MISC          32'h0000_0014

`define BMPM_CTRL_RST        32'h0000_0001
`define BMPM_HYS_RST         8'h05
`define BMPM_DLY_RST         8'h02
`define BMPM_OT_DLY_RST      8'h03
`define BMPM_RESHUT_RST      8'h0A
`define BMPM_MEMWIN_RST      8'h05

`define BMPM_B_SLEEP_CFG     0
`define BMPM_B_FASTCONV      1
`define BMPM_B_AUTO_SHUT     2
`define BMPM_B_OT_SHUT       3
`define BMPM_B_HWOT_SHUT     4
`define BMPM_B_LDO1_KEEP     5
`define BMPM_B_LDO2_KEEP     6
`define BMPM_B_LFO_KEEP      7
`define BMPM_B_RESHUT        8
`define BMPM_B_SLOW_VOLT     9

`define BMPM_CMD_SLP_ALLOW   4'h1
`define BMPM_CMD_SLP_FORBID  4'h2
`define BMPM_CMD_SLP_EXIT    4'h3
`define BMPM_CMD_DEEP_ENTER  4'h4
`define BMPM_CMD_DEEP_EXIT   4'h5
`define BMPM_CMD_SHUTDOWN    4'h6

`endif

// ---- bmpm_pkg.sv ----
// types for the battery monitor power-mode controller
package bmpm_pkg;

    typedef enum logic [2:0] {
        ST_NORMAL    = 3'b000,
        ST_SLEEP     = 3'b001,
        ST_DEEP      = 3'b010,
        ST_DEEP_EXIT = 3'b011,
        ST_SHUT_SEQ  = 3'b100,
        ST_SHUTDOWN  = 3'b101
    } bmpm_state_t;

    typedef struct packed {
        bmpm_state_t state;
        logic [31:0] ctrl;
        logic [7:0]  sleep_hys;
        logic [7:0]  shut_dly;
        logic [7:0]  ot_dly;
        logic [7:0]  reshut_min;
        logic [7:0]  mem_win;
        logic        sleep_allow;
        logic [31:0] tick;
        logic [31:0] sec_cnt;
        logic        sec_pulse;
        logic [31:0] cur_cnt;
        logic [31:0] volt_cnt;
        logic [31:0] slp_cnt;
        logic [31:0] gen_cnt;
        logic [7:0]  hys_left;
        logic [7:0]  ot_secs;
        logic [15:0] wake_secs;
        logic        woke;
        logic [7:0]  mem_secs;
        logic        mem_armed;
        logic        wait_boundary;
        logic        fets_on;
        logic        cur_smp;
        logic        volt_smp;
        logic        slp_smp;
        logic        wdog_rst;
        logic        rst_hi_prev;
        logic [31:0] rst_hi_cnt;
        logic        ld_prev;
        logic        ts2_prev;
        logic [31:0] prdata;
        logic [2:0]  s1;
        logic [2:0]  s2;
        logic [2:0]  s3;
    } bmpm_regs_t;

endpackage

// ---- bmpm_ctrl_monitor.sv ----
// assertion checker for the power-mode controller
`timescale 1ns/1ps
module bmpm_ctrl_monitor
(
    // bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // mode
    input wire logic        relaxed,
    input wire logic        sleep_current_over,
    input wire logic [2:0]  power_mode,
    input wire logic        charge_fet,
    input wire logic        discharge_fet,
    input wire logic        protections_en,
    input wire logic        current_sample,
    input wire logic        voltage_sample
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_state; power_mode <= 3'h5; endproperty
    a_state: assert property (p_state) else $error("mode code out of range");
    property p_slp_in; power_mode == 3'h1 && $past(power_mode) == 3'h0 |-> $past(relaxed);
    endproperty
    a_slp_in: assert property (p_slp_in) else $error("sleep entered while busy");
    property p_deep_in;
        power_mode == 3'h2 && $past(power_mode) != 3'h2
        |-> $past(psel && penable && pwrite && paddr == 32'h8 && pwdata[3:0] == 4'h4);
    endproperty
    a_deep_in: assert property (p_deep_in) else $error("deep state without command");
    property p_deep_off; power_mode == 3'h2 |-> !charge_fet && !discharge_fet && !protections_en;
    endproperty
    a_deep_off: assert property (p_deep_off) else $error("drive active in deep state");
    property p_deep_quiet; power_mode == 3'h2 |-> !current_sample && !voltage_sample; endproperty
    a_deep_quiet: assert property (p_deep_quiet) else $error("sampling in deep state");
    property p_shut_off; power_mode == 3'h5 |-> !charge_fet && !discharge_fet; endproperty
    a_shut_off: assert property (p_shut_off) else $error("fets on in shutdown");
    property p_pulse; current_sample |=> !current_sample; endproperty
    a_pulse: assert property (p_pulse) else $error("sample strobe too long");
    property p_slp_out;
        power_mode == 3'h1 && sleep_current_over
        |-> ##[1:16] (power_mode != 3'h1 || !sleep_current_over);
    endproperty
    a_slp_out: assert property (p_slp_out) else $error("sleep kept with current");
    property p_bus; pready && !pslverr; endproperty
    a_bus: assert property (p_bus) else $error("bus answer not ready");
    c_sleep: cover property (power_mode == 3'h1);
    c_dexit: cover property (power_mode == 3'h3);
    c_shut: cover property (power_mode == 3'h5);
endmodule
bind bmpm_ctrl bmpm_ctrl_monitor u_bmpm_ctrl_monitor (.*);

// ---- bmpm_host.sv ----
// host model issuing subcommands over apb
`timescale 1ns/1ps
module bmpm_host
(
    // bus
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [31:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready
);
    initial
    begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do
            @(posedge pclk);
        while (pready !== 1'h1);
        q = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic cmd(input logic [3:0] c);
        logic [31:0] q;
        xfer(1'h1, 32'h8, {28'h0, c}, q);
    endtask
endmodule

// ---- tb.sv ----
// testbench for the power-mode controller
`timescale 1ns/1ps
module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, q;
    logic        relaxed, sleep_current_over, stack_low;
    logic        reset_shut_pin, load_detect_pin, second_thermistor_wake_pin;
    logic [3:0]  wake_src;
    wire         interval_current_over = wake_src[0];
    wire         pack_delta_wake = wake_src[1];
    wire         protection_fault = wake_src[2];
    wire         charger_attached = wake_src[3];
    logic        cell_min_low, int_temp_over, hw_die_overtemp, battery_supply_low, mem_error;
    logic [2:0]  power_mode;
    logic        charge_fet, discharge_fet, protections_en, comparators_en, current_sample;
    logic        voltage_sample, fast_conversion, data_valid, ldo_output_one, ldo_output_two;
    logic        low_freq_oscillator, otp_reload, watchdog_reset;
    int          bad_count = 0;
    int          num_checks = 0;
    int          cyc = 0;

    bmpm_ctrl #(.SEC_CNT(20), .EXIT_CNT(10), .CUR_CNT(6), .VOLT_CNT(30), .SLP_CNT(12))
        u_bmpm_ctrl (.*);
    bmpm_host u_bmpm_host (.*);

    initial
    begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (bad_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, e);
        num_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wait_mode(input logic [2:0] m, input int n);
        int i;
        i = 0;
        #1;
        while (power_mode !== m && i < n)
        begin
            @(posedge pclk);
            #1;
            i++;
        end
        chk("power_mode", {29'h0, power_mode}, {29'h0, m});
    endtask
    task automatic wr(input logic [31:0] a, d);
        u_bmpm_host.xfer(1'h1, a, d, q);
    endtask
    task automatic rd(input logic [31:0] a);
        u_bmpm_host.xfer(1'h0, a, 32'h0, q);
    endtask

    initial
    begin
        presetn = 1'h0;
        {relaxed, sleep_current_over, stack_low, reset_shut_pin, load_detect_pin} = 5'h0;
        second_thermistor_wake_pin = 1'h1;
        {cell_min_low, int_temp_over, hw_die_overtemp, battery_supply_low, mem_error} = 5'h0;
        wake_src = 4'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        rd(32'h0);
        chk("ctrl", q, 32'h1);
        rd(32'h4);
        chk("status", q & 32'h1D, 32'h1);
        rd(32'h20);
        chk("unmapped", q, 32'h0);
        @(posedge pclk) relaxed <= 1'h1;
        wait_mode(3'h1, 8);
        rd(32'h4);
        chk("asleep", q & 32'h2, 32'h2);
        @(posedge pclk) sleep_current_over <= 1'h1;
        wait_mode(3'h0, 16);
        chk("discharge_fet", discharge_fet, 32'h1);
        chk("data_valid", data_valid, 32'h0);
        @(posedge pclk) sleep_current_over <= 1'h0;
        repeat (60) @(posedge pclk);
        wait_mode(3'h0, 0);
        wait_mode(3'h1, 150);
        wr(32'hC, 32'h0);
        wr(32'h8, 32'h2);
        wait_mode(3'h0, 5);
        u_bmpm_host.cmd(4'h1);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge pclk) relaxed <= 1'h1;
            wait_mode(3'h1, 8);
            @(posedge pclk) wake_src <= 4'h1 << i;
            relaxed <= 1'h0;
            wait_mode(3'h0, 70);
            @(posedge pclk) wake_src <= 4'h0;
        end
        u_bmpm_host.cmd(4'h4);
        wait_mode(3'h2, 5);
        chk("drive", {charge_fet, discharge_fet, protections_en, comparators_en}, 32'h0);
        chk("ldo", {ldo_output_one, ldo_output_two, low_freq_oscillator}, 32'h0);
        u_bmpm_host.cmd(4'h1);
        repeat (3) @(posedge pclk);
        wait_mode(3'h2, 0);
        u_bmpm_host.cmd(4'h5);
        wait_mode(3'h3, 4);
        wait_mode(3'h0, 60);
        u_bmpm_host.cmd(4'h4);
        wait_mode(3'h2, 5);
        @(posedge pclk) reset_shut_pin <= 1'h1;
        repeat (5) @(posedge pclk);
        reset_shut_pin <= 1'h0;
        wait_mode(3'h0, 80);
        @(posedge pclk) load_detect_pin <= 1'h1;
        u_bmpm_host.cmd(4'h6);
        wait_mode(3'h4, 5);
        repeat (120) @(posedge pclk);
        wait_mode(3'h4, 0);
        chk("fets", {charge_fet, discharge_fet}, 32'h0);
        @(posedge pclk) load_detect_pin <= 1'h0;
        wait_mode(3'h5, 30);
        @(posedge pclk) second_thermistor_wake_pin <= 1'h0;
        wait_mode(3'h0, 20);
        chk("otp_reload", otp_reload, 32'h1);
        @(posedge pclk) second_thermistor_wake_pin <= 1'h1;
        wr(32'h0, 32'h4);
        @(posedge pclk) stack_low <= 1'h1;
        wait_mode(3'h4, 5);
        stack_low <= 1'h0;
        wait_mode(3'h5, 100);
        @(posedge pclk) load_detect_pin <= 1'h1;
        wait_mode(3'h0, 20);
        rd(32'h0);
        chk("ctrl", q, 32'h1);
        @(posedge pclk) mem_error <= 1'h1;
        @(posedge pclk) mem_error <= 1'h0;
        #1 chk("watchdog_reset", watchdog_reset, 32'h1);
        @(posedge pclk) mem_error <= 1'h1;
        wait_mode(3'h4, 5);
        mem_error <= 1'h0;
        load_detect_pin <= 1'h0;
        wait_mode(3'h5, 100);
        @(posedge pclk) second_thermistor_wake_pin <= 1'h0;
        wait_mode(3'h0, 20);
        @(posedge pclk) second_thermistor_wake_pin <= 1'h1;
        u_bmpm_host.cmd(4'h4);
        wait_mode(3'h2, 5);
        battery_supply_low <= 1'h1;
        wait_mode(3'h5, 5);
        @(posedge pclk) second_thermistor_wake_pin <= 1'h0;
        battery_supply_low <= 1'h0;
        wait_mode(3'h0, 20);
        wr(32'h0, 32'hA);
        #1 chk("fast_conversion", fast_conversion, 32'h1);
        @(posedge pclk) hw_die_overtemp <= 1'h1;
        cell_min_low <= 1'h1;
        repeat (8) @(posedge pclk);
        wait_mode(3'h0, 0);
        int_temp_over <= 1'h1;
        wait_mode(3'h4, 90);
        print_verdict();
    end
endmodule
